// ===== fgr_pkg.sv
// package of constants and carrier types for the refresh granularity block
package fgr_pkg;
    // refresh mode field codes (mode register three)
    localparam logic [2:0] FGR_MODE_FIX1 = 3'h0;
    localparam logic [2:0] FGR_MODE_FIX2 = 3'h1;
    localparam logic [2:0] FGR_MODE_FIX4 = 3'h2;
    localparam logic [2:0] FGR_MODE_OTF2 = 3'h5;
    localparam logic [2:0] FGR_MODE_OTF4 = 3'h6;
    localparam logic [2:0] FGR_MODE_RST = FGR_MODE_FIX1;
    // field positions in the mode register address word
    localparam int FGR_MODE_LSB = 6;
    localparam int FGR_LAT_LSB = 6;
    localparam logic [1:0] FGR_MR_THREE = 2'h3;
    localparam logic [1:0] FGR_MR_FOUR = 2'h0;
    localparam logic [2:0] FGR_LAT_RST = 3'h0;
    // clock and timing
    localparam int FGR_CLK_PS = 100000;
    localparam int FGR_RFC1_NS = 350;
    localparam int FGR_RFC2_NS = 260;
    localparam int FGR_RFC4_NS = 160;
    localparam int FGR_REFI_BASE_NS = 7800;
    // least times round up to whole cycles
    localparam int FGR_RFC1_CYC = (FGR_RFC1_NS * 1000 + FGR_CLK_PS - 1) / FGR_CLK_PS;
    localparam int FGR_RFC2_CYC = (FGR_RFC2_NS * 1000 + FGR_CLK_PS - 1) / FGR_CLK_PS;
    localparam int FGR_RFC4_CYC = (FGR_RFC4_NS * 1000 + FGR_CLK_PS - 1) / FGR_CLK_PS;
    // average interval rounds down
    localparam int FGR_REFI1_CYC = (FGR_REFI_BASE_NS * 1000) / FGR_CLK_PS;
    localparam int FGR_REFI2_CYC = FGR_REFI1_CYC / 2;
    localparam int FGR_REFI4_CYC = FGR_REFI1_CYC / 4;
    // latency delay line length (largest field value)
    localparam int FGR_LAT_MAX = 7;

    // rate of a refresh
    typedef enum logic [1:0] {
        FGR_RATE_1X = 2'h0,
        FGR_RATE_2X = 2'h1,
        FGR_RATE_4X = 2'h3
    } fgr_rate_e;

    // command pins as captured
    typedef struct packed {
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic bg0;
        logic [1:0] ba;
        logic [13:0] addr;
    } fgr_cmd_s;

    // refresh timing outputs
    typedef struct packed {
        logic [11:0] refi_cyc;
        logic [11:0] rfc_cyc;
    } fgr_timing_s;
endpackage : fgr_pkg

// ===== fgr_cmd_delay.sv
// chip-select-to-command latency delay line with receiver enable
`timescale 1ns/100ps
module fgr_cmd_delay
    import fgr_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [2:0] lat_i,
    input wire logic cs_n_i,
    input wire fgr_cmd_s cmd_i,
    output fgr_cmd_s cmd_o,
    output logic cmd_vld_o,
    output logic rx_en_o
);
    typedef struct packed {
        logic [FGR_LAT_MAX:0] cs_pipe;
        logic [2:0] busy_cnt;
        logic cs_n_prev;
    } fgr_dly_s;

    fgr_dly_s st_ff;
    fgr_dly_s nxt_st;
    logic cap;
    logic start;

    // a chip select held over several cycles starts one command only
    assign start = !cs_n_i && st_ff.cs_n_prev;

    // capture point is lat cycles after chip select
    assign cap = (lat_i == 3'h0) ? start : st_ff.cs_pipe[lat_i - 3'h1];

    // shift command-start history, hold receivers on while commands pend
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cs_n_prev = cs_n_i;
        nxt_st.cs_pipe = {st_ff.cs_pipe[FGR_LAT_MAX-1:0], start};
        if (!cs_n_i) begin
            nxt_st.busy_cnt = lat_i;
        end else if (st_ff.busy_cnt != 3'h0) begin
            nxt_st.busy_cnt = st_ff.busy_cnt - 3'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_ff <= '0;
            // previous select idles high, so reset makes no false start
            st_ff.cs_n_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cmd_o = cmd_i;
    assign cmd_vld_o = cap;
    assign rx_en_o = (lat_i == 3'h0) || !cs_n_i || (st_ff.busy_cnt != 3'h0) || cap;
endmodule : fgr_cmd_delay

// ===== fgr_refresh_ctrl.sv
// refresh granularity mode logic of the memory device
//
// Overview of operation
// - capture command latency cycles after select
// - receivers may idle, stay on back-to-back
// - three-bit field selects refresh mode
// - reset leaves fixed 1x mode
// - bank-group bit picks rate on fly
// - refresh decoded from command pins
// - new timing applies at rate change
// - refresh type sets its own timing
// - same-rate fixed/fly switch not change
`timescale 1ns/100ps
module fgr_refresh_ctrl
    import fgr_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic act_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic bg0_i,
    input wire logic [1:0] ba_i,
    input wire logic [13:0] addr_i,
    input wire logic tcr_en_i,
    output logic [2:0] refresh_mode_o,
    output logic [2:0] cmd_latency_o,
    output logic rx_en_o,
    output logic ref_pulse_o,
    output logic [1:0] ref_rate_o,
    output fgr_timing_s timing_o,
    output logic [2:0] fine_count_o,
    output logic count_misaligned_o,
    output logic mode_illegal_o,
    output logic ref_illegal_o,
    output logic tcr_conflict_o
);
    typedef struct packed {
        fgr_cmd_s pin_a;
        fgr_cmd_s pin_b;
        fgr_cmd_s pin_c;
        fgr_cmd_s pin_q; // filtered pins, taken once stages two and three agree
        logic [2:0] mode;
        logic [2:0] lat;
        fgr_rate_e rate;
        logic [2:0] fine_cnt;
        logic ref_pulse;
        logic mode_bad;
        logic ref_bad;
        logic tcr_bad;
        fgr_timing_s tim;
    } fgr_state_s;

    fgr_state_s st_ff;
    fgr_state_s nxt_st;
    fgr_cmd_s pin_now;
    fgr_cmd_s cmd_d;
    logic cmd_vld;
    logic is_ref;
    logic is_mrs;
    fgr_rate_e req_rate;

    // rate that a mode field implies by itself
    function automatic fgr_rate_e mode_rate(input logic [2:0] m);
        case (m)
            FGR_MODE_FIX2, FGR_MODE_OTF2: mode_rate = FGR_RATE_2X;
            FGR_MODE_FIX4, FGR_MODE_OTF4: mode_rate = FGR_RATE_4X;
            default: mode_rate = FGR_RATE_1X;
        endcase
    endfunction : mode_rate

    // interval and cycle time for a rate
    function automatic fgr_timing_s rate_timing(input fgr_rate_e r);
        case (r)
            FGR_RATE_2X: rate_timing = '{refi_cyc: 12'(FGR_REFI2_CYC),
                                         rfc_cyc: 12'(FGR_RFC2_CYC)};
            FGR_RATE_4X: rate_timing = '{refi_cyc: 12'(FGR_REFI4_CYC),
                                         rfc_cyc: 12'(FGR_RFC4_CYC)};
            default: rate_timing = '{refi_cyc: 12'(FGR_REFI1_CYC),
                                     rfc_cyc: 12'(FGR_RFC1_CYC)};
        endcase
    endfunction : rate_timing

    // legal mode codes
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == FGR_MODE_FIX1) || (m == FGR_MODE_FIX2) || (m == FGR_MODE_FIX4)
            || (m == FGR_MODE_OTF2) || (m == FGR_MODE_OTF4);
    endfunction : mode_ok

    assign pin_now = '{cs_n: cs_n_i, act_n: act_n_i, ras_n: ras_n_i, cas_n: cas_n_i,
                       we_n: we_n_i, bg0: bg0_i, ba: ba_i, addr: addr_i};

    fgr_cmd_delay u_dly (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .lat_i(st_ff.lat),
        .cs_n_i(st_ff.pin_q.cs_n),
        .cmd_i(st_ff.pin_q),
        .cmd_o(cmd_d),
        .cmd_vld_o(cmd_vld),
        .rx_en_o(rx_en_o)
    );

    assign is_ref = cmd_vld && !cmd_d.act_n ? 1'b0 :
        cmd_vld && cmd_d.act_n && !cmd_d.ras_n && !cmd_d.cas_n && cmd_d.we_n;
    assign is_mrs = cmd_vld && cmd_d.act_n && !cmd_d.ras_n && !cmd_d.cas_n && !cmd_d.we_n;

    // on-the-fly rate pick from bank-group bit
    always_comb begin
        if (st_ff.mode[2] && !cmd_d.bg0) begin
            req_rate = FGR_RATE_1X;
        end else begin
            req_rate = mode_rate(st_ff.mode);
        end
    end

    // next state
    always_comb begin
        nxt_st = st_ff;
        // three-stage pin synchroniser, change taken once stages two and three agree
        // only stage two reads stage one, so a metastable first stage never reaches logic
        nxt_st.pin_a = pin_now;
        nxt_st.pin_b = st_ff.pin_a;
        nxt_st.pin_c = st_ff.pin_b;
        if (st_ff.pin_c == st_ff.pin_b) begin
            nxt_st.pin_q = st_ff.pin_c;
        end
        nxt_st.ref_pulse = 1'b0;
        nxt_st.tcr_bad = tcr_en_i && (st_ff.mode != FGR_MODE_FIX1);
        if (is_mrs && cmd_d.ba == FGR_MR_THREE) begin
            nxt_st.mode = cmd_d.addr[FGR_MODE_LSB +: 3];
            nxt_st.mode_bad = !mode_ok(cmd_d.addr[FGR_MODE_LSB +: 3]);
            if (mode_rate(cmd_d.addr[FGR_MODE_LSB +: 3]) != mode_rate(st_ff.mode)) begin
                nxt_st.rate = mode_rate(cmd_d.addr[FGR_MODE_LSB +: 3]);
                nxt_st.tim = rate_timing(mode_rate(cmd_d.addr[FGR_MODE_LSB +: 3]));
                nxt_st.fine_cnt = 3'h0;
            end
        end else if (is_mrs && cmd_d.ba == FGR_MR_FOUR) begin
            nxt_st.lat = cmd_d.addr[FGR_LAT_LSB +: 3];
        end else if (is_ref) begin
            nxt_st.ref_pulse = 1'b1;
            nxt_st.rate = req_rate;
            nxt_st.tim = rate_timing(req_rate);
            nxt_st.ref_bad = !mode_ok(st_ff.mode);
            // count fine refreshes, restart at a 1x refresh
            if (req_rate == FGR_RATE_1X) begin
                nxt_st.fine_cnt = 3'h0;
            end else begin
                nxt_st.fine_cnt = st_ff.fine_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_ff <= '0;
            st_ff.pin_a <= '1;
            st_ff.pin_b <= '1;
            st_ff.pin_c <= '1;
            st_ff.pin_q <= '1;
            st_ff.mode <= FGR_MODE_RST;
            st_ff.lat <= FGR_LAT_RST;
            st_ff.rate <= FGR_RATE_1X;
            st_ff.tim <= '{refi_cyc: 12'(FGR_REFI1_CYC), rfc_cyc: 12'(FGR_RFC1_CYC)};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign refresh_mode_o = st_ff.mode;
    assign cmd_latency_o = st_ff.lat;
    assign ref_pulse_o = st_ff.ref_pulse;
    assign ref_rate_o = st_ff.rate;
    assign timing_o = st_ff.tim;
    assign fine_count_o = st_ff.fine_cnt;
    assign count_misaligned_o = (st_ff.rate == FGR_RATE_2X) ? st_ff.fine_cnt[0]
        : (st_ff.rate == FGR_RATE_4X) ? (st_ff.fine_cnt[1:0] != 2'h0) : 1'b0;
    assign mode_illegal_o = st_ff.mode_bad;
    assign ref_illegal_o = st_ff.ref_bad;
    assign tcr_conflict_o = st_ff.tcr_bad;
endmodule : fgr_refresh_ctrl

// ===== fgr_refresh_checker.sv
// port-level assertions for the refresh granularity block
`timescale 1ns/100ps
module fgr_refresh_checker
    import fgr_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic tcr_en_i,
    input wire logic [2:0] refresh_mode_o,
    input wire logic ref_pulse_o,
    input wire logic [1:0] ref_rate_o,
    input wire fgr_timing_s timing_o,
    input wire logic [2:0] fine_count_o,
    input wire logic count_misaligned_o,
    input wire logic mode_illegal_o,
    input wire logic tcr_conflict_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    a_reset_state: assert property ($fell(srst_i) |-> refresh_mode_o == 3'h0
        && ref_rate_o == FGR_RATE_1X) else $error("state after reset is not fixed 1x");
    a_timing_normal: assert property (ref_rate_o == FGR_RATE_1X
        |-> timing_o == {12'h04e, 12'h004}) else $error("1x timing wrong");
    a_timing_double: assert property (ref_rate_o == FGR_RATE_2X
        |-> timing_o == {12'h027, 12'h003}) else $error("2x timing wrong");
    a_timing_quad: assert property (ref_rate_o == FGR_RATE_4X
        |-> timing_o == {12'h013, 12'h002}) else $error("4x timing wrong");
    a_parity_double: assert property (ref_rate_o == FGR_RATE_2X
        |-> count_misaligned_o == fine_count_o[0]) else $error("2x count flag wrong");
    a_parity_quad: assert property (ref_rate_o == FGR_RATE_4X
        |-> count_misaligned_o == (fine_count_o[1:0] != 2'h0)) else $error("4x flag wrong");
    a_normal_clears: assert property (ref_pulse_o && ref_rate_o == FGR_RATE_1X
        |-> fine_count_o == 3'h0) else $error("1x refresh left count");
    a_count_steady: assert property (!ref_pulse_o && $stable(refresh_mode_o)
        |-> $stable(fine_count_o)) else $error("count moved without cause");
    a_tcr_conflict: assert property (1'b1 |=> tcr_conflict_o ==
        $past(tcr_en_i && refresh_mode_o != 3'h0)) else $error("tcr conflict flag wrong");
    a_reserved_flag: assert property (mode_illegal_o ==
        (refresh_mode_o inside {3'h3, 3'h4, 3'h7})) else $error("reserved flag wrong");
endmodule : fgr_refresh_checker

bind fgr_refresh_ctrl fgr_refresh_checker u_chk (.clock_i(clock_i), .srst_i(srst_i),
    .tcr_en_i(tcr_en_i), .refresh_mode_o(refresh_mode_o), .ref_pulse_o(ref_pulse_o),
    .ref_rate_o(ref_rate_o), .timing_o(timing_o), .fine_count_o(fine_count_o),
    .count_misaligned_o(count_misaligned_o), .mode_illegal_o(mode_illegal_o),
    .tcr_conflict_o(tcr_conflict_o));

// ===== fgr_ctrl_model.sv
// memory controller model that drives the command pins
`timescale 1ns/100ps
module fgr_ctrl_model #(
    parameter int GAP = 30
) (
    input wire logic clock_i,
    output logic cs_n_o,
    output logic [3:0] pins_o,
    output logic bg0_o,
    output logic [1:0] ba_o,
    output logic [13:0] addr_o
);
    // deselected and idle at time zero
    initial begin
        cs_n_o = 1'b1;
        {pins_o, bg0_o, ba_o, addr_o} = '0;
    end

    task automatic issue(input logic [3:0] p, input logic b, input logic [1:0] s,
                         input logic [13:0] a);
        @(posedge clock_i);
        #10;
        cs_n_o = 1'b0;
        {pins_o, bg0_o, ba_o, addr_o} = {p, b, s, a};
        repeat (2) @(posedge clock_i);
        #10;
        // released lines show the inverse, not the last value
        cs_n_o = 1'b1;
        {pins_o, bg0_o, ba_o, addr_o} = ~{p, b, s, a};
        repeat (GAP) @(posedge clock_i);
        #10;
    endtask : issue

    // chip select leads the command by lat cycles, lat of two or more
    task automatic issue_cal(input logic [3:0] p, input logic b, input logic [1:0] s,
                             input logic [13:0] a, input int lat);
        @(posedge clock_i);
        #10;
        cs_n_o = 1'b0;
        repeat (2) @(posedge clock_i);
        #10;
        cs_n_o = 1'b1;
        repeat (lat - 2) @(posedge clock_i);
        #10;
        {pins_o, bg0_o, ba_o, addr_o} = {p, b, s, a};
        repeat (2) @(posedge clock_i);
        #10;
        {pins_o, bg0_o, ba_o, addr_o} = ~{p, b, s, a};
        repeat (GAP) @(posedge clock_i);
        #10;
    endtask : issue_cal
endmodule : fgr_ctrl_model

// ===== testbench.sv
// self-checking bench for the refresh granularity block
`timescale 1ns/100ps
module testbench;
    import fgr_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic tcr_en_i = 1'b0;
    logic cs_n, bg0, pulse, rx_en, misal, millg, rillg, tcr_c;
    logic [3:0] pins;
    logic [1:0] ba, rate;
    logic [13:0] addr;
    logic [2:0] mode, lat, cnt;
    fgr_timing_s tim;
    int bad_count = 0;
    int num_checks = 0;
    int pulses = 0;
    int cycles = 0;
    int mark = 0;

    // clock of 100 ns period
    always #50 clock_i = ~clock_i;

    fgr_ctrl_model u_ctl (.clock_i(clock_i), .cs_n_o(cs_n), .pins_o(pins), .bg0_o(bg0),
        .ba_o(ba), .addr_o(addr));
    fgr_refresh_ctrl u_dut (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n),
        .act_n_i(pins[3]), .ras_n_i(pins[2]), .cas_n_i(pins[1]), .we_n_i(pins[0]),
        .bg0_i(bg0), .ba_i(ba), .addr_i(addr), .tcr_en_i(tcr_en_i),
        .refresh_mode_o(mode), .cmd_latency_o(lat), .rx_en_o(rx_en), .ref_pulse_o(pulse),
        .ref_rate_o(rate), .timing_o(tim), .fine_count_o(cnt), .count_misaligned_o(misal),
        .mode_illegal_o(millg), .ref_illegal_o(rillg), .tcr_conflict_o(tcr_c));

    // count refresh pulses and cut a hang short
    always @(posedge clock_i) begin
        pulses <= pulses + ((pulse === 1'b1) ? 1 : 0);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            results();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic mrs(input logic [1:0] sel, input logic [2:0] code);
        u_ctl.issue(4'h8, 1'b0, sel, {5'h00, code, 6'h00});
    endtask : mrs

    // n refreshes, one pulse each, then rate, count and alignment flag
    task automatic refc(input logic b, input int n, input logic [1:0] r, input logic [2:0] c);
        int p0;
        logic m;
        p0 = pulses;
        m = (r == FGR_RATE_2X) ? c[0] : ((r == FGR_RATE_4X) ? (c[1:0] != 2'h0) : 1'b0);
        repeat (n) u_ctl.issue(4'h9, b, 2'h0, 14'h0000);
        chk(pulses - p0, n);
        chk({rate, cnt, misal}, {r, c, m});
    endtask : refc

    task automatic results();
        $display("checks=%0d errors=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // main sequence
    initial begin
        repeat (20) @(posedge clock_i);
        #10 srst_i = 1'b0;
        chk({mode, lat, rate, tim, cnt, millg, rillg}, {8'h00, 12'h04e, 12'h004, 5'h00});
        chk(rx_en, 1'b1);
        refc(1'b1, 1, FGR_RATE_1X, 3'h0);
        for (int k = 0; k < 8; k++) begin
            mrs(FGR_MR_THREE, k[2:0]);
            chk({mode, millg}, {k[2:0], k inside {3, 4, 7}});
        end
        refc(1'b1, 1, FGR_RATE_1X, 3'h0);
        chk(rillg, 1'b1);
        mrs(FGR_MR_THREE, FGR_MODE_OTF2);
        refc(1'b1, 1, FGR_RATE_2X, 3'h1);
        refc(1'b1, 1, FGR_RATE_2X, 3'h2);
        refc(1'b0, 1, FGR_RATE_1X, 3'h0);
        mrs(FGR_MR_THREE, FGR_MODE_OTF4);
        refc(1'b1, 3, FGR_RATE_4X, 3'h3);
        refc(1'b1, 1, FGR_RATE_4X, 3'h4);
        mrs(FGR_MR_THREE, FGR_MODE_FIX2);
        chk({rate, cnt, tim}, {FGR_RATE_2X, 3'h0, 12'h027, 12'h003});
        refc(1'b0, 1, FGR_RATE_2X, 3'h1);
        mrs(FGR_MR_THREE, FGR_MODE_OTF2);
        chk({rate, cnt}, {FGR_RATE_2X, 3'h1});
        refc(1'b1, 1, FGR_RATE_2X, 3'h2);
        mrs(FGR_MR_THREE, FGR_MODE_FIX4);
        chk({rate, cnt, tim}, {FGR_RATE_4X, 3'h0, 12'h013, 12'h002});
        tcr_en_i = 1'b1;
        repeat (3) @(posedge clock_i);
        #10 chk(tcr_c, 1'b1);
        mrs(FGR_MR_THREE, FGR_MODE_FIX1);
        chk({tcr_c, rate}, {1'b0, FGR_RATE_1X});
        mrs(FGR_MR_FOUR, 3'h3);
        chk({lat, mode, rx_en}, {3'h3, 3'h0, 1'b0});
        mark = pulses;
        u_ctl.issue_cal(4'h9, 1'b0, 2'h0, 14'h0000, 3);
        chk(pulses - mark, 1);
        chk({rate, cnt, rx_en}, {FGR_RATE_1X, 3'h0, 1'b0});
        srst_i = 1'b1;
        @(posedge clock_i);
        #10 srst_i = 1'b0;
        chk({mode, lat, rate, cnt}, 11'h000);
        results();
    end
endmodule : testbench
